// [cfg_bank.sv]
/*
  Configuration register bank of a three-channel delta-sigma converter:
  link behaviour, conversion timing, amplifier and output/chop registers,
  decoded settings, the sample-ready pin and the auxiliary output pin.
  Assumes an SPI command decoder on the same clock that issues one-cycle
  register reads and writes, and a datapath that pulses per-channel ready.
*/
// What this block does
// - Bit 13 of link register enables register-map CRC checking; resets off.
// - Bit 12 enables CRC checking of incoming SPI words; resets off.
// - Bit 11 picks CCITT (0) or ANSI (1) 16-bit CRC polynomial.
// - Bit 10 resets to one; writing zero clears the status reset indicator.
// - Bits 9:8 choose 16, 24, 32 zero-padded or 32 sign-extended words.
// - Bit 4 enables the SPI timeout; resets to enabled.
// - Bits 3:2 pick lagging, any, or leading enabled channel for ready pin.
// - With no data, ready pin is driven high or floats per bit 1.
// - With data, ready pin is held low or pulsed low per bit 0.
// - Timing bits 10:8 enable channels 2, 1, 0; all reset enabled.
// - Bits 7:6 divide input clock by 2, 4, 8 or 12.
// - Fast bit 5 forces oversampling ratio 64, ignoring ratio field.
// - Bits 4:2 give ratio 128 doubling to 16384; reset code 011.
// - Power code 01 low power, 10 high resolution; host avoids 00, 11.
// - Three-bit gain fields per channel select gain 2 to the n.
// - Aux enable turns third positive input into output driving aux level.
// - Settle code selects 2 doubling upward modulator periods; resets to 16.
// - Bit 8 of output and chop register enables global chop.
module cfg_bank
  import cfg_bank_pkg::*;
#(
  parameter int PULSE_CYCLES = RDY_PULSE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic [2:0] CHAN_DATA_READY,
  input wire logic DATA_TAKEN,
  output logic REGMAP_CHECK_EN,
  output logic INPUT_CHECK_EN,
  output logic CHECK_POLY_ANSI,
  output logic STATUS_RESET_CLR,
  output logic [1:0] SAMPLE_WORD_SIZE,
  output logic [5:0] WORD_BITS,
  output logic SPI_TIMEOUT_EN,
  output logic SAMPLE_READY_OUT,
  output logic SAMPLE_READY_OE_N,
  output logic [2:0] CHANNEL_ENABLE,
  output logic [3:0] INPUT_DIVIDE,
  output logic [14:0] OVERSAMPLE_RATIO,
  output logic [1:0] POWER_PROFILE,
  output logic [23:0] AMP_GAIN,
  output logic THIRD_INPUT_POS_OUT,
  output logic THIRD_INPUT_POS_OE_N,
  output logic [16:0] CHOP_SETTLE_PERIODS,
  output logic CHOP_ENABLE
);

  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction : gain_of

  function automatic logic [15:0] write_val(input logic [15:0] cur, input logic [15:0] mask,
                                           input logic hit, input logic [15:0] data);
    write_val = hit ? (data & mask) : cur;
  endfunction : write_val

  logic [15:0] link_reg, link_next;
  logic [15:0] timing_reg, timing_next;
  logic [15:0] amp_reg, amp_next;
  logic [15:0] aux_reg, aux_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rst_clr_reg, rst_clr_next;
  logic [5:0] word_bits_reg, word_bits_next;
  logic [3:0] divide_reg, divide_next;
  logic [14:0] osr_reg, osr_next;
  logic [23:0] gain_reg, gain_next;
  logic [16:0] settle_reg, settle_next;
  logic [2:0] pend_reg, pend_next;
  logic avail_reg, avail_next;
  logic [7:0] pulse_cnt_reg, pulse_cnt_next;
  logic rdy_out_reg, rdy_out_next;
  logic rdy_oe_n_reg, rdy_oe_n_next;
  logic aux_out_reg, aux_out_next;
  logic aux_oe_n_reg, aux_oe_n_next;
  logic [2:0] en_now;
  logic [2:0] live;
  logic low_phase;

  always_comb begin
    link_next = write_val(link_reg, LINK_MASK, REG_WR && REG_ADDR == ADDR_LINK, REG_WDATA);
    timing_next = write_val(timing_reg, TIMING_MASK, REG_WR && REG_ADDR == ADDR_TIMING,
                            REG_WDATA);
    amp_next = write_val(amp_reg, AMP_MASK, REG_WR && REG_ADDR == ADDR_AMP, REG_WDATA);
    aux_next = write_val(aux_reg, AUX_MASK, REG_WR && REG_ADDR == ADDR_AUX, REG_WDATA);
    // The clear request is a pulse; the status flag itself lives elsewhere.
    rst_clr_next = REG_WR && REG_ADDR == ADDR_LINK && !REG_WDATA[LB_RESET_SEEN];
    rdata_next = rdata_reg;
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_LINK: rdata_next = link_reg;
        ADDR_TIMING: rdata_next = timing_reg;
        ADDR_AMP: rdata_next = amp_reg;
        ADDR_AUX: rdata_next = aux_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
    case (link_next[LB_WORD_LO +: 2])
      2'h0: word_bits_next = 6'h10;
      2'h1: word_bits_next = 6'h18;
      default: word_bits_next = 6'h20;
    endcase
    case (timing_next[CT_DIV_LO +: 2])
      2'h0: divide_next = 4'h2;
      2'h1: divide_next = 4'h4;
      2'h2: divide_next = 4'h8;
      default: divide_next = 4'hc;
    endcase
    if (timing_next[CT_FAST]) begin
      osr_next = OSR_FAST;
    end else begin
      osr_next = OSR_BASE << timing_next[CT_OSR_LO +: 3];
    end
    gain_next = {gain_of(amp_next[AMP_CH2_LO +: 3]), gain_of(amp_next[AMP_CH1_LO +: 3]),
                 gain_of(amp_next[AMP_CH0_LO +: 3])};
    settle_next = SETTLE_BASE << aux_next[AX_SETTLE_LO +: 4];
    aux_out_next = aux_next[AX_OUT_EN] ? aux_next[AX_OUT_LEVEL] : 1'b0;
    aux_oe_n_next = !aux_next[AX_OUT_EN];
  end

  // A ready pulse arriving together with the data-taken strobe stays pending.
  always_comb begin
    en_now = timing_reg[CT_CHAN_EN_LO +: 3];
    pend_next = ((DATA_TAKEN ? 3'h0 : pend_reg) | CHAN_DATA_READY) & en_now;
    live = pend_next;
    case (link_reg[LB_RDY_SRC_LO +: 2])
      RDY_LAGGING: avail_next = (live == en_now) && (en_now != 3'h0);
      RDY_ANY: avail_next = live != 3'h0;
      default: avail_next = (live != 3'h0) && (pend_reg == 3'h0 || avail_reg);
    endcase
    pulse_cnt_next = pulse_cnt_reg;
    if (avail_next && !avail_reg) begin
      pulse_cnt_next = 8'(PULSE_CYCLES);
    end else if (pulse_cnt_reg != 8'h00) begin
      pulse_cnt_next = pulse_cnt_reg - 8'h01;
    end
    if (link_reg[LB_RDY_PULSE]) begin
      low_phase = pulse_cnt_next != 8'h00;
    end else begin
      low_phase = avail_next;
    end
    if (low_phase) begin
      rdy_out_next = 1'b0;
      rdy_oe_n_next = 1'b0;
    end else begin
      rdy_out_next = 1'b1;
      // Follow the incoming write so the float setting lands with the register itself.
      rdy_oe_n_next = link_next[LB_RDY_FLOAT];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      link_reg <= LINK_RESET;
      timing_reg <= TIMING_RESET;
      amp_reg <= AMP_RESET;
      aux_reg <= AUX_RESET;
      rdata_reg <= 16'h0000;
      rst_clr_reg <= 1'b0;
      word_bits_reg <= 6'h18;
      divide_reg <= 4'h2;
      osr_reg <= 15'h0400;
      gain_reg <= 24'h010101;
      settle_reg <= 17'h00010;
      pend_reg <= 3'h0;
      avail_reg <= 1'b0;
      pulse_cnt_reg <= 8'h00;
      rdy_out_reg <= 1'b1;
      rdy_oe_n_reg <= 1'b0;
      aux_out_reg <= 1'b0;
      aux_oe_n_reg <= 1'b1;
    end else begin
      link_reg <= link_next;
      timing_reg <= timing_next;
      amp_reg <= amp_next;
      aux_reg <= aux_next;
      rdata_reg <= rdata_next;
      rst_clr_reg <= rst_clr_next;
      word_bits_reg <= word_bits_next;
      divide_reg <= divide_next;
      osr_reg <= osr_next;
      gain_reg <= gain_next;
      settle_reg <= settle_next;
      pend_reg <= pend_next;
      avail_reg <= avail_next;
      pulse_cnt_reg <= pulse_cnt_next;
      rdy_out_reg <= rdy_out_next;
      rdy_oe_n_reg <= rdy_oe_n_next;
      aux_out_reg <= aux_out_next;
      aux_oe_n_reg <= aux_oe_n_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REGMAP_CHECK_EN = link_reg[LB_REGMAP_CHK];
  assign INPUT_CHECK_EN = link_reg[LB_INPUT_CHK];
  assign CHECK_POLY_ANSI = link_reg[LB_POLY_SEL];
  assign STATUS_RESET_CLR = rst_clr_reg;
  assign SAMPLE_WORD_SIZE = link_reg[LB_WORD_LO +: 2];
  assign WORD_BITS = word_bits_reg;
  assign SPI_TIMEOUT_EN = link_reg[LB_TIMEOUT];
  assign SAMPLE_READY_OUT = rdy_out_reg;
  assign SAMPLE_READY_OE_N = rdy_oe_n_reg;
  assign CHANNEL_ENABLE = timing_reg[CT_CHAN_EN_LO +: 3];
  assign INPUT_DIVIDE = divide_reg;
  assign OVERSAMPLE_RATIO = osr_reg;
  assign POWER_PROFILE = timing_reg[CT_POWER_LO +: 2];
  assign AMP_GAIN = gain_reg;
  assign THIRD_INPUT_POS_OUT = aux_out_reg;
  assign THIRD_INPUT_POS_OE_N = aux_oe_n_reg;
  assign CHOP_SETTLE_PERIODS = settle_reg;
  assign CHOP_ENABLE = aux_reg[AX_CHOP_EN];

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  chk_link_write_lands: assert property (
    REG_WR && REG_ADDR == ADDR_LINK |=> link_reg == ($past(REG_WDATA) & LINK_MASK))
    else $error("link register did not take the write");
  chk_read_returns: assert property (
    REG_RD && !REG_WR && REG_ADDR == ADDR_TIMING |=> REG_RDATA == timing_reg)
    else $error("timing read returned wrong data");
  chk_reset_clear_pulse: assert property (
    REG_WR && REG_ADDR == ADDR_LINK && !REG_WDATA[LB_RESET_SEEN] |=> STATUS_RESET_CLR ##1
    !STATUS_RESET_CLR || $past(REG_WR))
    else $error("reset indicator clear pulse missing");
  chk_fast_ratio: assert property (
    REG_WR && REG_ADDR == ADDR_TIMING && REG_WDATA[CT_FAST] |=> OVERSAMPLE_RATIO == 15'h0040)
    else $error("fast mode ratio not 64");
  chk_ratio_decode: assert property (
    REG_WR && REG_ADDR == ADDR_TIMING && !REG_WDATA[CT_FAST] && REG_WDATA[4:2] == 3'h7
    |=> OVERSAMPLE_RATIO == 15'h4000)
    else $error("ratio code 7 not 16384");
  chk_divide_decode: assert property (
    REG_WR && REG_ADDR == ADDR_TIMING && REG_WDATA[7:6] == 2'h3 |=> INPUT_DIVIDE == 4'hc)
    else $error("divider code 3 not 12");
  chk_word_bits: assert property (
    SAMPLE_WORD_SIZE == 2'h0 |-> WORD_BITS == 6'h10)
    else $error("16-bit word size mismatch");
  chk_ready_idle_float: assert property (
    !avail_reg && pulse_cnt_reg == 8'h00 |-> SAMPLE_READY_OUT && SAMPLE_READY_OE_N ==
    link_reg[LB_RDY_FLOAT])
    else $error("ready pin idle state wrong");
  chk_ready_pulse_len: assert property (
    link_reg[LB_RDY_PULSE] && avail_next && !avail_reg && $stable(link_reg) |=>
    !SAMPLE_READY_OUT [*2])
    else $error("ready low pulse too short");
  chk_ready_held_low: assert property (
    !link_reg[LB_RDY_PULSE] && avail_reg |-> !SAMPLE_READY_OUT && !SAMPLE_READY_OE_N)
    else $error("ready pin not held low");
  chk_aux_drive: assert property (
    aux_reg[AX_OUT_EN] |-> !THIRD_INPUT_POS_OE_N && THIRD_INPUT_POS_OUT ==
    aux_reg[AX_OUT_LEVEL])
    else $error("aux output not driving level");
  chk_gain_ch2: assert property (
    AMP_GAIN[23:16] == (8'h01 << amp_reg[AMP_CH2_LO +: 3]))
    else $error("channel 2 gain decode wrong");
  chk_settle_decode: assert property (
    CHOP_SETTLE_PERIODS == (17'h00002 << aux_reg[AX_SETTLE_LO +: 4]))
    else $error("settle delay decode wrong");

  cov_pulse_mode: cover property (link_reg[LB_RDY_PULSE] && !SAMPLE_READY_OUT);
  cov_lagging_ready: cover property (link_reg[3:2] == RDY_LAGGING && avail_reg);
  cov_reset_clear: cover property (STATUS_RESET_CLR);
  cov_aux_on: cover property (!THIRD_INPUT_POS_OE_N && THIRD_INPUT_POS_OUT);
endmodule : cfg_bank

// [cfg_bank_pkg.sv]
/*
  Constants of the converter configuration register bank: register indices,
  field positions, writable masks, reset values and pin timing.
  Assumes nothing of its surroundings; every other design file imports it.
*/
package cfg_bank_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // Register indices on the internal register port.
  localparam logic [5:0] ADDR_LINK = 6'h02;
  localparam logic [5:0] ADDR_TIMING = 6'h03;
  localparam logic [5:0] ADDR_AMP = 6'h04;
  localparam logic [5:0] ADDR_AUX = 6'h06;

  localparam logic [15:0] LINK_RESET = 16'h0510;
  localparam logic [15:0] TIMING_RESET = 16'h070e;
  localparam logic [15:0] AMP_RESET = 16'h0000;
  localparam logic [15:0] AUX_RESET = 16'h0600;

  // Reserved bits are not stored and read back as zero.
  localparam logic [15:0] LINK_MASK = 16'h3f1f;
  localparam logic [15:0] TIMING_MASK = 16'h07ff;
  localparam logic [15:0] AMP_MASK = 16'h0777;
  localparam logic [15:0] AUX_MASK = 16'h7f00;

  // Link behaviour register fields.
  localparam int LB_REGMAP_CHK = 13;
  localparam int LB_INPUT_CHK = 12;
  localparam int LB_POLY_SEL = 11;
  localparam int LB_RESET_SEEN = 10;
  localparam int LB_WORD_LO = 8;
  localparam int LB_TIMEOUT = 4;
  localparam int LB_RDY_SRC_LO = 2;
  localparam int LB_RDY_FLOAT = 1;
  localparam int LB_RDY_PULSE = 0;

  // Conversion timing register fields.
  localparam int CT_CHAN_EN_LO = 8;
  localparam int CT_DIV_LO = 6;
  localparam int CT_FAST = 5;
  localparam int CT_OSR_LO = 2;
  localparam int CT_POWER_LO = 0;

  // Amplifier setting fields, channel 0 first.
  localparam int AMP_CH0_LO = 0;
  localparam int AMP_CH1_LO = 4;
  localparam int AMP_CH2_LO = 8;

  // Output and chop register fields.
  localparam int AX_OUT_EN = 14;
  localparam int AX_OUT_LEVEL = 13;
  localparam int AX_SETTLE_LO = 9;
  localparam int AX_CHOP_EN = 8;

  localparam logic [1:0] RDY_LAGGING = 2'h0;
  localparam logic [1:0] RDY_ANY = 2'h1;

  localparam logic [14:0] OSR_BASE = 15'h0080;
  localparam logic [14:0] OSR_FAST = 15'h0040;
  localparam logic [16:0] SETTLE_BASE = 17'h00002;

  // Low pulse on the ready pin, in ns, turned into core clock cycles.
  localparam int CLK_PERIOD_NS = 10;
  localparam int RDY_PULSE_NS = 80;
  localparam int RDY_PULSE_CYC = (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : cfg_bank_pkg

// [host_model.sv]
/*
  Host-side model of the register port: one-cycle register writes and reads.
  Assumes the bank samples its strobes on the rising edge of CORE_CLK.
*/
module host_model
  import cfg_bank_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic [DATA_W-1:0] REG_RDATA,
  output logic REG_WR,
  output logic REG_RD,
  output logic [ADDR_W-1:0] REG_ADDR,
  output logic [DATA_W-1:0] REG_WDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 6'h00;
    REG_WDATA = 16'h0000;
  end
  // Reserved bits of the four mapped registers leave as zero; other addresses get the caller's data unchanged.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    case (a)
      ADDR_LINK: REG_WDATA <= d & LINK_MASK;
      ADDR_TIMING: REG_WDATA <= d & TIMING_MASK;
      ADDR_AMP: REG_WDATA <= d & AMP_MASK;
      ADDR_AUX: REG_WDATA <= d & AUX_MASK;
      default: REG_WDATA <= d;
    endcase
    if (a == ADDR_TIMING && d[1:0] != 2'h1 && d[1:0] != 2'h2) begin
      $display("BAD host sent a reserved power code");
    end
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
    @(posedge CORE_CLK);
    d = REG_RDATA;
  endtask : rd
endmodule : host_model

// [tb.sv]
/*
  Self-checking bench of the configuration register bank.
  Assumes the host model drives the register port; the bench drives channel events.
*/
module tb
  import cfg_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // A short ready pulse keeps the pulse-mode check quick.
  localparam int PC = 2;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, regmap_chk, input_chk, poly_ansi, rst_clr, timeout_en;
  logic rdy_out, rdy_oe_n, aux_out, aux_oe_n, chop_en;
  logic [5:0] reg_addr, word_bits;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] chan_ready = 3'h0;
  logic data_taken = 1'b0;
  logic [1:0] word_size, power;
  logic [2:0] chan_en;
  logic [3:0] in_div;
  logic [14:0] oversample_ratio;
  logic [23:0] gain;
  logic [16:0] settle;
  int errors = 0;
  int compares = 0;
  cfg_bank #(.PULSE_CYCLES(PC)) i_cfg_bank (.CORE_CLK(core_clk), .RST(rst),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .CHAN_DATA_READY(chan_ready), .DATA_TAKEN(data_taken),
    .REGMAP_CHECK_EN(regmap_chk), .INPUT_CHECK_EN(input_chk), .CHECK_POLY_ANSI(poly_ansi),
    .STATUS_RESET_CLR(rst_clr), .SAMPLE_WORD_SIZE(word_size), .WORD_BITS(word_bits),
    .SPI_TIMEOUT_EN(timeout_en), .SAMPLE_READY_OUT(rdy_out), .SAMPLE_READY_OE_N(rdy_oe_n),
    .CHANNEL_ENABLE(chan_en), .INPUT_DIVIDE(in_div), .OVERSAMPLE_RATIO(oversample_ratio),
    .POWER_PROFILE(power), .AMP_GAIN(gain), .THIRD_INPUT_POS_OUT(aux_out),
    .THIRD_INPUT_POS_OE_N(aux_oe_n), .CHOP_SETTLE_PERIODS(settle), .CHOP_ENABLE(chop_en));
  host_model i_host_model (.CORE_CLK(core_clk), .REG_RDATA(reg_rdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata));
  always #5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic wrs(input logic [5:0] a, input logic [15:0] d);
    i_host_model.wr(a, d);
    #1;
  endtask : wrs
  task automatic rdc(input string n, input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host_model.rd(a, d);
    chk(n, d, exp);
  endtask : rdc
  task automatic ev(input logic [2:0] v, input logic t);
    @(posedge core_clk);
    chan_ready <= v;
    data_taken <= t;
    @(posedge core_clk);
    chan_ready <= 3'h0;
    data_taken <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : ev
  task automatic t_reset();
    rdc("link", ADDR_LINK, 16'h0510);
    rdc("timing", ADDR_TIMING, 16'h070e);
    rdc("amp", ADDR_AMP, 16'h0000);
    rdc("aux", ADDR_AUX, 16'h0600);
    rdc("unmapped", 6'h05, 16'h0000);
    chk("word", word_bits, 24'h18);
    chk("timeout", timeout_en, 24'h1);
    chk("osr", oversample_ratio, 24'h400);
    chk("settle", settle, 24'h10);
    chk("gain", gain, 24'h010101);
    chk("aux", {aux_oe_n, chop_en, regmap_chk, input_chk}, 24'h8);
  endtask : t_reset
  task automatic t_link();
    logic p;
    wrs(ADDR_LINK, 16'h0000);
    p = rst_clr;
    @(posedge core_clk);
    #1 p = p | rst_clr;
    chk("clear", p, 24'h1);
    chk("off", {regmap_chk, input_chk, poly_ansi, timeout_en}, 24'h0);
    for (int c = 0; c < 4; c++) begin
      wrs(ADDR_LINK, 16'h3810 | (16'(c) << 8));
      chk("bits", word_bits, (c == 0) ? 16 : (c == 1) ? 24 : 32);
      chk("size", word_size, c);
      chk("on", {regmap_chk, input_chk, poly_ansi, timeout_en}, 24'hf);
    end
    wrs(ADDR_LINK, 16'h0510);
    chk("noclear", rst_clr, 24'h0);
  endtask : t_link
  task automatic t_timing();
    for (int c = 0; c < 4; c++) begin
      wrs(ADDR_TIMING, 16'h0001 | (16'(c) << 6));
      chk("div", in_div, (c == 3) ? 12 : 2 << c);
      chk("pwr_chen", {power, chan_en}, 24'h8);
    end
    for (int c = 0; c < 8; c++) begin
      wrs(ADDR_TIMING, 16'h0502 | (16'(c) << 2));
      chk("osr", oversample_ratio, 128 << c);
      chk("chen", chan_en, 24'h5);
    end
    wrs(ADDR_TIMING, 16'h072e);
    chk("fast", oversample_ratio, 24'h40);
    rdc("timing", ADDR_TIMING, 16'h072e);
    wrs(ADDR_TIMING, 16'h070e);
  endtask : t_timing
  task automatic t_amp_aux();
    wrs(ADDR_AMP, 16'h0753);
    chk("gain", gain, 24'h802008);
    wrs(ADDR_AMP, 16'h0210);
    chk("gain", gain, 24'h040201);
    wrs(ADDR_AUX, 16'h6100);
    chk("aux", {aux_oe_n, aux_out, chop_en}, 24'h3);
    chk("settle", settle, 24'h2);
    wrs(ADDR_AUX, 16'h5a00);
    chk("aux", {aux_oe_n, aux_out, chop_en}, 24'h0);
    chk("settle", settle, 24'h4000);
    rdc("aux", ADDR_AUX, 16'h5a00);
  endtask : t_amp_aux
  task automatic t_ready();
    wrs(ADDR_LINK, 16'h0514);
    chk("idle", {rdy_out, rdy_oe_n}, 24'h2);
    ev(3'h2, 1'b0);
    chk("any", {rdy_out, rdy_oe_n}, 24'h0);
    repeat (3) @(posedge core_clk);
    #1 chk("held", {rdy_out, rdy_oe_n}, 24'h0);
    ev(3'h0, 1'b1);
    chk("taken", {rdy_out, rdy_oe_n}, 24'h2);
    wrs(ADDR_LINK, 16'h0510);
    ev(3'h3, 1'b0);
    chk("lag", rdy_out, 24'h1);
    ev(3'h4, 1'b0);
    chk("lag", rdy_out, 24'h0);
    ev(3'h0, 1'b1);
    wrs(ADDR_LINK, 16'h0516);
    chk("float", rdy_oe_n, 24'h1);
    wrs(ADDR_LINK, 16'h0518);
    ev(3'h1, 1'b0);
    chk("lead", {rdy_out, rdy_oe_n}, 24'h0);
    ev(3'h0, 1'b1);
    wrs(ADDR_LINK, 16'h0515);
    ev(3'h1, 1'b0);
    chk("pulse", {rdy_out, rdy_oe_n}, 24'h0);
    repeat (PC) @(posedge core_clk);
    #1 chk("pulse_end", rdy_out, 24'h1);
    ev(3'h0, 1'b1);
  endtask : t_ready
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_link();
    t_timing();
    t_amp_aux();
    t_ready();
    wrap_up();
  end
  // Guard against a hang; running out counts as a mismatch.
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
endmodule : tb
